// ### core/cetim_edge.sv
// synchroniser and edge detector for the external count input
`timescale 1ns/1ps
module cetim_edge
  import cetim_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   rst,
  input  wire logic   pin,
  cetim_tick_if.edge_mp tk
);
  logic s1;
  logic s2;
  logic s3;
  logic next_s1;
  logic next_s2;
  logic next_s3;

  always_comb begin
    next_s1 = pin;
    next_s2 = s1;
    next_s3 = s2;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  // edges are seen only past the second stage, avoiding metastable reads
  assign tk.rise = s2 & ~s3; // R17
  assign tk.fall = ~s2 & s3; // R17
endmodule

// ### core/cetim_pkg.sv
// constants of the cascaded 16-bit event timer
// Behaviour
// (R1) low counter counts selected external input edge
// (R2) low overflow clocks high counter in cascade
// (R3) full 16-bit match clears both, raises high irq
// (R4) low match still raises low irq, toggles
// (R5) software masks low irq for 16-bit use
// (R6) 16-bit count read returns both bytes together
// (R7) software splits compare value high/low bytes
// (R8) output enable bit toggles second output per match
// (R9) bits 6 and 7 preset second output level
// (R10) first match may lag one count clock
// (R11) compare value 00h matches every pulse
// (R12) software writes compares only while stopped
// (R13) lowered compare wraps, never matches early
// (R14) software restarts after lowering compare
// (R15) cascade select bit 2 enables 16-bit mode
// (R16) count enable bit alone starts and stops pair
// (R17) external input synchronised, edge detected
// (R18) second output toggles with full match
package cetim_pkg;

  localparam logic [5:0] ADDR_MODE     = 6'h00;
  localparam logic [5:0] ADDR_CLKSEL   = 6'h04;
  localparam logic [5:0] ADDR_OSC      = 6'h08;
  localparam logic [5:0] ADDR_CMP_LO   = 6'h0C;
  localparam logic [5:0] ADDR_CMP_HI   = 6'h10;
  localparam logic [5:0] ADDR_OUTCTL   = 6'h14;
  localparam logic [5:0] ADDR_COUNT    = 6'h18;
  localparam logic [5:0] ADDR_IRQ_STAT = 6'h1C;
  localparam logic [5:0] ADDR_IRQ_EN   = 6'h20;
  localparam logic [5:0] ADDR_IRQ_CLR  = 6'h24;

  localparam int MODE_CE_BIT    = 0;
  localparam int MODE_CASC_BIT  = 2;
  localparam int OC_LO_PRE_LOW  = 2;
  localparam int OC_LO_PRE_HIGH = 3;
  localparam int OC_HI_EN_BIT   = 4;
  localparam int OC_HI_PRE_LOW  = 6;
  localparam int OC_HI_PRE_HIGH = 7;
  localparam int OSC_HALVE_BIT  = 0;
  localparam int IRQ_LO_BIT     = 0;
  localparam int IRQ_HI_BIT     = 1;

  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [3:0] RST_CLKSEL = 4'h0;
  localparam logic [1:0] RST_IRQ    = 2'h0;

  localparam logic [3:0] CLK_EXT_RISE  = 4'h0;
  localparam logic [3:0] CLK_EXT_FALL  = 4'h1;
  localparam logic [3:0] CLK_PRE_FIRST = 4'h6;
  localparam logic [3:0] CLK_PRE_MAX   = 4'hF;
  localparam logic [3:0] PRE_EXP_BASE  = 4'h5;
  localparam logic [3:0] PRE_EXP_TOP   = 4'hB;
  localparam int         PRE_W         = 12;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } cetim_bus_type;

endpackage

// ### core/cetim_prescale.sv
// free running prescaler giving one-cycle count enables
`timescale 1ns/1ps
module cetim_prescale
  import cetim_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  rst,
  cetim_tick_if.pre_mp tk
);
  logic [PRE_W-1:0] cnt;
  logic [PRE_W-1:0] next_cnt;
  logic [PRE_W-1:0] mask;
  logic [3:0]       expo;
  logic             valid;

  // free running: start is not aligned to a count pulse
  always_comb begin
    next_cnt = cnt + {{(PRE_W-1){1'b0}}, 1'b1};
    valid    = (tk.clk_sel >= CLK_PRE_FIRST);
    expo     = (tk.clk_sel == CLK_PRE_MAX) ? PRE_EXP_TOP
             : tk.clk_sel - PRE_EXP_BASE;
    if (!tk.halve_sel) begin
      expo = expo + 4'h1;
    end
    mask = (PRE_W'(1) << expo) - PRE_W'(1);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign tk.pre_tick = valid && ((cnt & mask) == mask); // R10
endmodule

// ### core/cetim_tick_if.sv
// count source signals between the timer core and its helpers
`timescale 1ns/1ps
interface cetim_tick_if;
  logic [3:0] clk_sel;
  logic       halve_sel;
  logic       rise;
  logic       fall;
  logic       pre_tick;
  modport edge_mp (output rise, output fall);
  modport pre_mp  (input clk_sel, input halve_sel, output pre_tick);
  modport core_mp (output clk_sel, output halve_sel,
                   input rise, input fall, input pre_tick);
endinterface

// ### core/cetim_top.sv
// cascaded 16-bit timer / event counter with avalon register slave
`timescale 1ns/1ps
module cetim_top
  import cetim_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        external_count_input,
  output logic             irq,
  output logic             first_timer_output,
  output logic             second_timer_output
);

  ////////////////////////////////////////////////////////////////////
  cetim_tick_if tk ();

  cetim_edge u_edge (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin     (external_count_input),
    .tk      (tk.edge_mp)
  );

  cetim_prescale u_pre (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tk      (tk.pre_mp)
  );

  ////////////////////////////////////////////////////////////////////
  cetim_bus_type bus_state;
  cetim_bus_type next_bus_state;
  logic [7:0]    timer_mode_ctrl_reg;
  logic [3:0]    count_clock_select_reg;
  logic [7:0]    oscillation_mode_reg;
  logic [7:0]    low_compare_reg;
  logic [7:0]    high_compare_reg;
  logic [7:0]    output_control_reg;
  logic [7:0]    low_count_reg;
  logic [7:0]    high_count_reg;
  logic [1:0]    irq_stat;
  logic [1:0]    irq_en;
  logic [7:0]    next_mode;
  logic [3:0]    next_clksel;
  logic [7:0]    next_osc;
  logic [7:0]    next_cmp_lo;
  logic [7:0]    next_cmp_hi;
  logic [7:0]    next_outctl;
  logic [7:0]    next_low;
  logic [7:0]    next_high;
  logic [1:0]    next_irq_stat;
  logic [1:0]    next_irq_en;
  logic [1:0]    irq_set;
  logic [1:0]    irq_clr;
  logic [31:0]   next_readdata;
  logic          next_waitrequest;
  logic          next_irq;
  logic          next_out1;
  logic          next_out2;
  logic          count_enable_bit;
  logic          cascade_select;
  logic          tick;
  logic          match_lo;
  logic          match_full;
  logic          wr_take;
  logic          oc_write;

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    return {24'h000000, b};
  endfunction

  assign count_enable_bit = timer_mode_ctrl_reg[MODE_CE_BIT];
  assign cascade_select   = timer_mode_ctrl_reg[MODE_CASC_BIT];
  assign tk.clk_sel       = count_clock_select_reg;
  assign tk.halve_sel     = oscillation_mode_reg[OSC_HALVE_BIT];
  assign match_lo         = (low_count_reg == low_compare_reg);
  assign match_full       = match_lo && (high_count_reg == high_compare_reg);
  assign wr_take          = avs_write && (bus_state == BUS_ACK);
  assign oc_write         = wr_take && (avs_address == ADDR_OUTCTL);

  // count source: synchronised pin edge or prescaler enable
  always_comb begin
    unique case (count_clock_select_reg)
      CLK_EXT_RISE: tick = count_enable_bit && tk.rise; // R1
      CLK_EXT_FALL: tick = count_enable_bit && tk.fall; // R1
      default:      tick = count_enable_bit && tk.pre_tick;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    next_bus_state   = bus_state;
    next_waitrequest = 1'b1;
    next_readdata    = avs_readdata;
    next_mode        = timer_mode_ctrl_reg;
    next_clksel      = count_clock_select_reg;
    next_osc         = oscillation_mode_reg;
    next_cmp_lo      = low_compare_reg;
    next_cmp_hi      = high_compare_reg;
    next_outctl      = output_control_reg;
    next_low         = low_count_reg;
    next_high        = high_count_reg;
    next_irq_en      = irq_en;
    next_out1        = first_timer_output;
    next_out2        = second_timer_output;
    irq_set          = RST_IRQ;
    irq_clr          = RST_IRQ;

    // counting
    if (!count_enable_bit) begin
      next_low  = RST_BYTE; // R16
      next_high = RST_BYTE; // R16
    end else if (tick) begin
      if (match_lo) begin
        irq_set[IRQ_LO_BIT] = 1'b1; // R4
        next_out1 = ~first_timer_output; // R4
      end
      if (cascade_select) begin // R15
        if (match_full) begin
          next_low  = RST_BYTE; // R3
          next_high = RST_BYTE; // R3
          irq_set[IRQ_HI_BIT] = 1'b1; // R3
          if (output_control_reg[OC_HI_EN_BIT]) begin
            next_out2 = ~second_timer_output; // R8 R18
          end
        end else begin
          // compare below count simply wraps through ffffh
          next_low = low_count_reg + 8'h01; // R13
          if (low_count_reg == 8'hFF) begin
            next_high = high_count_reg + 8'h01; // R2
          end
        end
      end else begin
        next_high = RST_BYTE;
        next_low  = match_lo ? RST_BYTE : low_count_reg + 8'h01; // R11
      end
    end

    // bus: one wait cycle, read word captured on entry
    unique case (bus_state)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_bus_state   = BUS_ACK;
          next_waitrequest = 1'b0;
          unique case (avs_address)
            ADDR_MODE:     next_readdata = byte_word(timer_mode_ctrl_reg);
            ADDR_CLKSEL:   next_readdata = {28'h0000000,
                                            count_clock_select_reg};
            ADDR_OSC:      next_readdata = byte_word(oscillation_mode_reg);
            ADDR_CMP_LO:   next_readdata = byte_word(low_compare_reg);
            ADDR_CMP_HI:   next_readdata = byte_word(high_compare_reg);
            ADDR_OUTCTL:   next_readdata = byte_word(output_control_reg);
            ADDR_COUNT:    next_readdata = {16'h0000, high_count_reg,
                                            low_count_reg}; // R6
            ADDR_IRQ_STAT: next_readdata = {30'h0, irq_stat};
            ADDR_IRQ_EN:   next_readdata = {30'h0, irq_en};
            default:       next_readdata = 32'h00000000;
          endcase
        end
      end
      BUS_ACK: begin
        next_bus_state = BUS_IDLE;
      end
    endcase

    // output control presets override match toggles of the same cycle
    if (wr_take) begin
      unique case (avs_address)
        ADDR_MODE:    next_mode   = avs_writedata[7:0];
        ADDR_CLKSEL:  next_clksel = avs_writedata[3:0];
        ADDR_OSC:     next_osc    = avs_writedata[7:0];
        ADDR_CMP_LO:  next_cmp_lo = avs_writedata[7:0];
        ADDR_CMP_HI:  next_cmp_hi = avs_writedata[7:0];
        ADDR_OUTCTL: begin
          next_outctl = avs_writedata[7:0];
          if (avs_writedata[OC_LO_PRE_HIGH]) begin
            next_out1 = 1'b1;
          end else if (avs_writedata[OC_LO_PRE_LOW]) begin
            next_out1 = 1'b0;
          end
          if (avs_writedata[OC_HI_PRE_HIGH]) begin
            next_out2 = 1'b1; // R9
          end else if (avs_writedata[OC_HI_PRE_LOW]) begin
            next_out2 = 1'b0; // R9
          end
        end
        ADDR_IRQ_EN:  next_irq_en = avs_writedata[1:0];
        ADDR_IRQ_CLR: irq_clr     = avs_writedata[1:0];
        default: begin
        end
      endcase
    end

    // set beats clear so no event is lost
    next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
    next_irq      = |(irq_stat & irq_en);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_state              <= BUS_IDLE;
      avs_waitrequest        <= 1'b1;
      avs_readdata           <= 32'h00000000;
      timer_mode_ctrl_reg    <= RST_BYTE;
      count_clock_select_reg <= RST_CLKSEL;
      oscillation_mode_reg   <= RST_BYTE;
      low_compare_reg        <= RST_BYTE;
      high_compare_reg       <= RST_BYTE;
      output_control_reg     <= RST_BYTE;
      low_count_reg          <= RST_BYTE;
      high_count_reg         <= RST_BYTE;
      irq_stat               <= RST_IRQ;
      irq_en                 <= RST_IRQ;
      irq                    <= 1'b0;
      first_timer_output     <= 1'b0;
      second_timer_output    <= 1'b0;
    end else begin
      bus_state              <= next_bus_state;
      avs_waitrequest        <= next_waitrequest;
      avs_readdata           <= next_readdata;
      timer_mode_ctrl_reg    <= next_mode;
      count_clock_select_reg <= next_clksel;
      oscillation_mode_reg   <= next_osc;
      low_compare_reg        <= next_cmp_lo;
      high_compare_reg       <= next_cmp_hi;
      output_control_reg     <= next_outctl;
      low_count_reg          <= next_low;
      high_count_reg         <= next_high;
      irq_stat               <= next_irq_stat;
      irq_en                 <= next_irq_en;
      irq                    <= next_irq;
      first_timer_output     <= next_out1;
      second_timer_output    <= next_out2;
    end
  end

  ////////////////////////////////////////////////////////////////////
  full_match_clear_a: assert property ( // R3
    @(posedge clk_sys) disable iff (rst)
    tick && cascade_select && match_full && !wr_take
      |=> low_count_reg == 8'h00 && high_count_reg == 8'h00
          && irq_stat[IRQ_HI_BIT])
    else $error("full match did not clear counters");

  low_match_flag_a: assert property ( // R4
    @(posedge clk_sys) disable iff (rst)
    tick && match_lo && !oc_write
      |=> irq_stat[IRQ_LO_BIT]
          && first_timer_output != $past(first_timer_output))
    else $error("low match did not flag and toggle");

  high_carry_a: assert property ( // R2
    @(posedge clk_sys) disable iff (rst)
    tick && cascade_select && !match_full && low_count_reg == 8'hFF
      && !wr_take
      |=> low_count_reg == 8'h00
          && high_count_reg == $past(high_count_reg) + 8'h01)
    else $error("low overflow did not carry");

  wrap_count_a: assert property ( // R13
    @(posedge clk_sys) disable iff (rst)
    tick && cascade_select && !match_full && low_count_reg != 8'hFF
      && !wr_take
      |=> low_count_reg == $past(low_count_reg) + 8'h01
          && high_count_reg == $past(high_count_reg))
    else $error("count did not advance by one");

  stopped_clear_a: assert property ( // R16
    @(posedge clk_sys) disable iff (rst)
    !count_enable_bit |=> low_count_reg == 8'h00
                          && high_count_reg == 8'h00)
    else $error("stopped timer holds a count");

  square_toggle_a: assert property ( // R18
    @(posedge clk_sys) disable iff (rst)
    tick && cascade_select && match_full
      && output_control_reg[OC_HI_EN_BIT] && !oc_write
      |=> second_timer_output != $past(second_timer_output))
    else $error("second output missed a toggle");

  square_hold_a: assert property ( // R8
    @(posedge clk_sys) disable iff (rst)
    !output_control_reg[OC_HI_EN_BIT] && !oc_write
      |=> $stable(second_timer_output))
    else $error("second output moved while disabled");

  preset_high_a: assert property ( // R9
    @(posedge clk_sys) disable iff (rst)
    oc_write && avs_writedata[OC_HI_PRE_HIGH]
      |=> second_timer_output)
    else $error("second output preset failed");

  ext_edge_a: assert property ( // R1
    @(posedge clk_sys) disable iff (rst)
    count_enable_bit && count_clock_select_reg == CLK_EXT_RISE
      && cascade_select && tk.rise && !match_full
      && low_count_reg != 8'hFF && !wr_take
      |=> low_count_reg == $past(low_count_reg) + 8'h01)
    else $error("external edge not counted");

  count_read_a: assert property ( // R6
    @(posedge clk_sys) disable iff (rst)
    bus_state == BUS_IDLE && avs_read && avs_address == ADDR_COUNT
      |=> avs_readdata[15:0] == {$past(high_count_reg),
                                 $past(low_count_reg)}
          && !avs_waitrequest)
    else $error("count read torn or late");

endmodule

// ### tb/cetim_pulse_src.sv
// external pulse source: toggles the count pin a given number of times
`timescale 1ns/1ps
module cetim_pulse_src #(
  parameter int HOLD = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [15:0] n_edges,
  output logic             pin,
  output logic             busy
);
  logic [15:0] left;
  logic [3:0]  gap;
  // each level is held HOLD cycles: shorter levels may be lost in the
  // input synchroniser, so the source never runs faster than that
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin  <= 1'b0;
      busy <= 1'b0;
      left <= 16'h0000;
      gap  <= 4'h0;
    end else if (go && !busy) begin
      left <= n_edges;
      busy <= (n_edges != 16'h0000);
      gap  <= 4'h0;
    end else if (busy) begin
      if (gap == 4'(HOLD - 1)) begin
        pin  <= ~pin;
        gap  <= 4'h0;
        left <= left - 16'h0001;
        busy <= (left != 16'h0001);
      end else begin
        gap <= gap + 4'h1;
      end
    end
  end
endmodule

// ### tb/tb.sv
// self-checking bench for the cascaded event timer
`timescale 1ns/1ps
module tb
  import cetim_pkg::*;
;
  logic        clk_sys;
  logic        rst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        out1;
  logic        out2;
  logic        pin;
  logic        go;
  logic        busy;
  logic        prev1;
  logic [15:0] n_edges;
  logic [31:0] rd;
  logic [5:0]  ra [7];
  int          n_errors;
  int          check_count;
  int          t;

  cetim_top i_cetim_top (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .avs_address          (avs_address),
    .avs_read             (avs_read),
    .avs_write            (avs_write),
    .avs_writedata        (avs_writedata),
    .avs_readdata         (avs_readdata),
    .avs_waitrequest      (avs_waitrequest),
    .external_count_input (pin),
    .irq                  (irq),
    .first_timer_output   (out1),
    .second_timer_output  (out2)
  );

  cetim_pulse_src i_cetim_pulse_src (
    .clk_sys (clk_sys),
    .rst     (rst),
    .go      (go),
    .n_edges (n_edges),
    .pin     (pin),
    .busy    (busy)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one avalon access; the request stands until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_errors++;
      final_report();
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string what, input logic [5:0] a,
                     input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  // pin toggles, then time for synchroniser, counter and irq to settle
  task automatic edges(input int n);
    int k;
    @(posedge clk_sys);
    go      <= 1'b1;
    n_edges <= 16'(n);
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    k = 0;
    while (busy === 1'b1 && k < 20000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 20000) begin
      n_errors++;
      final_report();
    end
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic start(input logic [3:0] cs, input logic [15:0] cmp,
                       input logic [7:0] mode);
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_CLKSEL, {28'h0, cs});
    wr(ADDR_CMP_HI, {24'h0, cmp[15:8]});
    wr(ADDR_CMP_LO, {24'h0, cmp[7:0]});
    wr(ADDR_IRQ_CLR, 32'h3);
    wr(ADDR_MODE, {24'h0, mode});
  endtask

  // waits for irq after a start; returns the cycle count in t
  task automatic irq_time();
    t = 0;
    while (irq !== 1'b1 && t < 200) begin
      @(posedge clk_sys);
      t++;
    end
    if (t >= 200) begin
      n_errors++;
      final_report();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    rst = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    go = 1'b0;
    n_edges = 16'h0000;
    n_errors = 0;
    check_count = 0;
    ra = '{ADDR_MODE, ADDR_CLKSEL, ADDR_CMP_LO, ADDR_CMP_HI,
           ADDR_OUTCTL, ADDR_COUNT, 6'h3C};
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (ra[i]) rdc("reset value", ra[i], 32'h0);
    chk("irq at reset", 32'(irq), 32'h0);
    $display("test reset done");
    // pin starts low: five toggles hold three rises, then four from high
    start(CLK_EXT_RISE, 16'hFFFF, 8'h05);
    edges(5);
    rdc("rising count", ADDR_COUNT, 32'h3);
    start(CLK_EXT_FALL, 16'hFFFF, 8'h05);
    edges(4);
    rdc("falling count", ADDR_COUNT, 32'h2);
    wr(ADDR_MODE, 32'h4);
    edges(4);
    rdc("stopped count", ADDR_COUNT, 32'h0);
    $display("test edge select done");
    start(CLK_EXT_RISE, 16'hFFFF, 8'h05);
    edges(600);
    rdc("carry into high", ADDR_COUNT, 32'h012C);
    $display("test cascade done");
    start(CLK_EXT_RISE, 16'h0502, 8'h01);
    rdc("cmp high", ADDR_CMP_HI, 32'h05);
    edges(6);
    rdc("eight bit count", ADDR_COUNT, 32'h0);
    rdc("eight bit status", ADDR_IRQ_STAT, 32'h1);
    $display("test single mode done");
    wr(ADDR_IRQ_EN, 32'h3);
    wr(ADDR_OUTCTL, 32'h10);
    start(CLK_EXT_RISE, 16'h0002, 8'h05);
    prev1 = out1;
    edges(6);
    rdc("match count", ADDR_COUNT, 32'h0);
    rdc("match status", ADDR_IRQ_STAT, 32'h3);
    chk("irq on match", 32'(irq), 32'h1);
    chk("square out", 32'(out2), 32'h1);
    chk("low output", 32'(out1), {31'h0, ~prev1});
    edges(2);
    rdc("count after match", ADDR_COUNT, 32'h1);
    wr(ADDR_IRQ_EN, 32'h2);
    wr(ADDR_IRQ_CLR, 32'h3);
    edges(4);
    chk("square out back", 32'(out2), 32'h0);
    wr(ADDR_IRQ_CLR, 32'h2);
    rdc("low left", ADDR_IRQ_STAT, 32'h1);
    chk("masked irq", 32'(irq), 32'h0);
    $display("test match done");
    wr(ADDR_OUTCTL, 32'h80);
    repeat (2) @(posedge clk_sys);
    chk("preset high", 32'(out2), 32'h1);
    wr(ADDR_OUTCTL, 32'h40);
    repeat (2) @(posedge clk_sys);
    chk("preset low", 32'(out2), 32'h0);
    wr(ADDR_OUTCTL, 32'h00);
    start(CLK_EXT_RISE, 16'h0000, 8'h05);
    edges(2);
    rdc("one pulse status", ADDR_IRQ_STAT, 32'h3);
    rdc("one pulse count", ADDR_COUNT, 32'h0);
    chk("no toggle", 32'(out2), 32'h0);
    $display("test preset done");
    start(CLK_EXT_RISE, 16'hFFFF, 8'h05);
    edges(10);
    wr(ADDR_CMP_HI, 32'h0);
    wr(ADDR_CMP_LO, 32'h2);
    wr(ADDR_IRQ_CLR, 32'h3);
    edges(6);
    rdc("no early match", ADDR_COUNT, 32'h8);
    rdc("no early status", ADDR_IRQ_STAT, 32'h0);
    start(CLK_EXT_RISE, 16'h0002, 8'h05);
    edges(6);
    rdc("restart match", ADDR_IRQ_STAT, 32'h3);
    $display("test lowered compare done");
    // prescaled start may slip by up to one count clock
    wr(ADDR_OSC, 32'h1);
    start(CLK_PRE_FIRST, 16'h0009, 8'h05);
    irq_time();
    chk("fast interval", 32'(t >= 17 && t <= 26), 32'h1);
    wr(ADDR_OSC, 32'h0);
    start(CLK_PRE_FIRST, 16'h0009, 8'h05);
    irq_time();
    chk("slow interval", 32'(t >= 37 && t <= 46), 32'h1);
    $display("test interval done");
    final_report();
  end
endmodule
